// *** design/i2cm_master.sv ***
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module i2cm_master (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            highSpeedMode,
  output logic            irq
);
  i2cm_pkg::i2cm_state_type state_reg;
  i2cm_pkg::i2cm_cmd_type   cmd_reg;
  logic [7:0] target_address_reg;
  logic [7:0] transfer_data_reg;
  logic [7:0] rx_byte_reg;
  logic [7:0] clock_period_value;
  logic       glitch_filter_enable;
  logic       clear_reg;
  logic       line_occupied;
  logic       arbitration_lost_flag, data_nack_flag, address_nack_flag;
  logic       owner_reg, addrPhase_reg, isRead_reg, hsPhase_reg;
  logic [7:0] shift_reg;
  logic [2:0] bitCnt_reg;
  logic [1:0] phase_reg;
  logic [9:0] tick_reg;
  logic       sclDrvLow, sdaDrvLow;
  logic [1:0] sclSync, sdaSync;
  logic       sclF, sdaF, sdaPrev, sclPrev;
  logic [2:0] sclCnt, sdaCnt;
  logic       cmdWrite, busWide;
  logic [9:0] quarter;
  logic       tickEn, sclLowSeen;

  assign cmdWrite = regWr && regAddr == i2cm_pkg::ADDR_CMDSTAT;

  // Synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
    end
    else
    begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
    end
  end

  // Glitch filter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sclF   <= 1'b1;
      sdaF   <= 1'b1;
      sclCnt <= 3'h0;
      sdaCnt <= 3'h0;
    end
    else
    begin
      if (!glitch_filter_enable || sclSync[1] == sclF)
        sclCnt <= 3'h0;
      else
        sclCnt <= sclCnt + 3'h1;
      if (!glitch_filter_enable || (sclSync[1] != sclF && 32'(sclCnt) >= i2cm_pkg::FILTER_CYCLES))
        sclF <= sclSync[1];
      if (!glitch_filter_enable || sdaSync[1] == sdaF)
        sdaCnt <= 3'h0;
      else
        sdaCnt <= sdaCnt + 3'h1;
      if (!glitch_filter_enable || (sdaSync[1] != sdaF && 32'(sdaCnt) >= i2cm_pkg::FILTER_CYCLES))
        sdaF <= sdaSync[1];
    end
  end

  // Bus occupancy from START and STOP of any master
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sdaPrev       <= 1'b1;
      sclPrev       <= 1'b1;
      line_occupied <= 1'b0;
    end
    else
    begin
      sdaPrev <= sdaF;
      sclPrev <= sclF;
      if (sclF && sclPrev && sdaPrev && !sdaF)
        line_occupied <= 1'b1;
      else if (sclF && sclPrev && !sdaPrev && sdaF)
        line_occupied <= 1'b0;
    end
  end

  // Quarter period: 2*(1+period) clocks, floor 3 keeps SCL at most system/12
  assign busWide = 32'((10'(clock_period_value) + 10'h1) * 10'(i2cm_pkg::QUARTER_MULT))
                   < i2cm_pkg::MIN_QUARTER;
  assign quarter = busWide ? 10'(i2cm_pkg::MIN_QUARTER)
                           : (10'(clock_period_value) + 10'h1) * 10'(i2cm_pkg::QUARTER_MULT);
  // Timer waits at end of high quarter while others hold SCL low
  assign sclLowSeen = !sclDrvLow && !sclSync[1] && phase_reg == 2'h2;
  assign tickEn     = tick_reg == quarter - 10'h1 && !sclLowSeen;

  always_ff @(posedge sys_clk)
  begin
    if (rst || clear_reg || state_reg == i2cm_pkg::ST_IDLE_S || tickEn)
      tick_reg <= 10'h0;
    else if (tick_reg != quarter - 10'h1)
      tick_reg <= tick_reg + 10'h1;
  end

  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      target_address_reg   <= i2cm_pkg::RST_TARGET;
      transfer_data_reg    <= i2cm_pkg::RST_DATA;
      clock_period_value   <= i2cm_pkg::RST_PERIOD;
      glitch_filter_enable <= 1'b0;
    end
    else if (regWr)
    begin
      if (regAddr == i2cm_pkg::ADDR_TARGET)
        target_address_reg <= regWdata;
      if (regAddr == i2cm_pkg::ADDR_DATA)
        transfer_data_reg <= regWdata;
      if (regAddr == i2cm_pkg::ADDR_PERIOD)
        clock_period_value <= regWdata;
      if (cmdWrite)
        glitch_filter_enable <= regWdata[i2cm_pkg::CMD_FILT];
    end
  end

  // Clear pulse self-clears after one cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      clear_reg <= 1'b0;
    else
      clear_reg <= cmdWrite && regWdata[i2cm_pkg::CMD_CLEAR];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRd)
      unique case (regAddr)
        i2cm_pkg::ADDR_TARGET:  regRdata <= target_address_reg;
        i2cm_pkg::ADDR_DATA:    regRdata <= rx_byte_reg;
        i2cm_pkg::ADDR_PERIOD:  regRdata <= clock_period_value;
        i2cm_pkg::ADDR_CMDSTAT: regRdata <= {1'b0, line_occupied,
          state_reg == i2cm_pkg::ST_IDLE_S,
          arbitration_lost_flag, data_nack_flag, address_nack_flag,
          arbitration_lost_flag | data_nack_flag | address_nack_flag,
          state_reg != i2cm_pkg::ST_IDLE_S && state_reg != i2cm_pkg::ST_HOLD};
        default:                regRdata <= 8'h00;
      endcase
    else
      regRdata <= 8'h00;
  end

  // Master sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst || clear_reg)
    begin
      state_reg             <= i2cm_pkg::ST_IDLE_S;
      cmd_reg               <= '0;
      shift_reg             <= 8'h00;
      rx_byte_reg           <= 8'h00;
      bitCnt_reg            <= 3'h0;
      phase_reg             <= 2'h0;
      sclDrvLow             <= 1'b0;
      sdaDrvLow             <= 1'b0;
      owner_reg             <= 1'b0;
      addrPhase_reg         <= 1'b0;
      isRead_reg            <= 1'b0;
      hsPhase_reg           <= 1'b0;
      highSpeedMode         <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      data_nack_flag        <= 1'b0;
      address_nack_flag     <= 1'b0;
      irq                   <= 1'b0;
    end
    else
    begin
      irq <= 1'b0;
      if (cmdWrite && regWdata[i2cm_pkg::CMD_RUN] &&
          (state_reg == i2cm_pkg::ST_IDLE_S || state_reg == i2cm_pkg::ST_HOLD))
      begin
        cmd_reg               <= '{regWdata[i2cm_pkg::CMD_START], regWdata[i2cm_pkg::CMD_STOP],
                                   regWdata[i2cm_pkg::CMD_ACK], regWdata[i2cm_pkg::CMD_HS]};
        arbitration_lost_flag <= 1'b0;
        data_nack_flag        <= 1'b0;
        address_nack_flag     <= 1'b0;
        phase_reg             <= 2'h0;
        if (regWdata[i2cm_pkg::CMD_HS] && state_reg == i2cm_pkg::ST_IDLE_S)
        begin
          hsPhase_reg <= 1'b1;
          state_reg   <= i2cm_pkg::ST_WAITBUS;
        end
        else if (regWdata[i2cm_pkg::CMD_START])
          state_reg <= owner_reg ? i2cm_pkg::ST_RSTART : i2cm_pkg::ST_WAITBUS;
        else if (owner_reg)
          state_reg <= i2cm_pkg::ST_PREP;
      end
      else if (cmdWrite && regWdata[i2cm_pkg::CMD_STOP] && state_reg == i2cm_pkg::ST_HOLD)
      begin
        phase_reg <= 2'h0;
        state_reg <= i2cm_pkg::ST_STOP;
      end
      else
        unique case (state_reg)
          i2cm_pkg::ST_IDLE_S, i2cm_pkg::ST_HOLD: ;
          i2cm_pkg::ST_WAITBUS:
            if (!line_occupied)
              state_reg <= i2cm_pkg::ST_START;
          i2cm_pkg::ST_RSTART:
            if (tickEn)
            begin
              phase_reg <= phase_reg + 2'h1;
              unique case (phase_reg)
                // SCL low first so SDA rises without a STOP
                2'h0: sclDrvLow <= 1'b1;
                2'h1: sdaDrvLow <= 1'b0;
                2'h2: sclDrvLow <= 1'b0;
                2'h3: state_reg <= i2cm_pkg::ST_START;
              endcase
            end
          i2cm_pkg::ST_START:
            if (tickEn)
            begin
              sdaDrvLow     <= 1'b1;
              owner_reg     <= 1'b1;
              addrPhase_reg <= !hsPhase_reg;
              isRead_reg    <= target_address_reg[0];
              shift_reg     <= hsPhase_reg ? i2cm_pkg::MASTER_CODE : target_address_reg;
              bitCnt_reg    <= 3'h7;
              phase_reg     <= 2'h0;
              state_reg     <= i2cm_pkg::ST_BITS;
            end
          i2cm_pkg::ST_PREP:
          begin
            addrPhase_reg <= 1'b0;
            shift_reg     <= transfer_data_reg;
            bitCnt_reg    <= 3'h7;
            phase_reg     <= 2'h0;
            state_reg     <= i2cm_pkg::ST_BITS;
          end
          i2cm_pkg::ST_BITS, i2cm_pkg::ST_ACKBIT:
            if (tickEn)
            begin
              phase_reg <= phase_reg + 2'h1;
              unique case (phase_reg)
                2'h0:
                begin
                  sclDrvLow <= 1'b1;
                  if (state_reg == i2cm_pkg::ST_BITS)
                    sdaDrvLow <= (isRead_reg && !addrPhase_reg) ? 1'b0 : !shift_reg[7];
                  else
                    sdaDrvLow <= isRead_reg && !addrPhase_reg && cmd_reg.ack;
                end
                2'h1: sclDrvLow <= 1'b0;
                2'h2:
                  if (state_reg == i2cm_pkg::ST_BITS)
                  begin
                    // Released SDA read low means another master won
                    if (!sdaDrvLow && !sdaF && !(isRead_reg && !addrPhase_reg))
                    begin
                      arbitration_lost_flag <= 1'b1;
                      sclDrvLow             <= 1'b0;
                      owner_reg             <= 1'b0;
                      hsPhase_reg           <= 1'b0;
                      irq                   <= 1'b1;
                      state_reg             <= i2cm_pkg::ST_IDLE_S;
                    end
                    shift_reg <= {shift_reg[6:0], sdaF};
                  end
                  else if (sdaF && !(isRead_reg && !addrPhase_reg) && !hsPhase_reg)
                  begin
                    if (addrPhase_reg)
                      address_nack_flag <= 1'b1;
                    else
                      data_nack_flag <= 1'b1;
                  end
                2'h3:
                  if (state_reg == i2cm_pkg::ST_BITS)
                  begin
                    bitCnt_reg <= bitCnt_reg - 3'h1;
                    if (bitCnt_reg == 3'h0)
                    begin
                      state_reg <= i2cm_pkg::ST_ACKBIT;
                      if (isRead_reg && !addrPhase_reg)
                        rx_byte_reg <= shift_reg;
                    end
                  end
                  else if (hsPhase_reg)
                  begin
                    hsPhase_reg   <= 1'b0;
                    highSpeedMode <= 1'b1;
                    irq           <= 1'b1;
                    state_reg     <= i2cm_pkg::ST_HOLD;
                  end
                  else if (address_nack_flag || data_nack_flag)
                    state_reg <= i2cm_pkg::ST_STOP;
                  else if (addrPhase_reg)
                  begin
                    addrPhase_reg <= 1'b0;
                    shift_reg     <= transfer_data_reg;
                    bitCnt_reg    <= 3'h7;
                    state_reg     <= i2cm_pkg::ST_BITS;
                  end
                  else if (cmd_reg.stop)
                    state_reg <= i2cm_pkg::ST_STOP;
                  else
                  begin
                    irq       <= 1'b1;
                    state_reg <= i2cm_pkg::ST_HOLD;
                  end
              endcase
            end
          i2cm_pkg::ST_STOP:
            if (tickEn)
            begin
              phase_reg <= phase_reg + 2'h1;
              unique case (phase_reg)
                2'h0:
                begin
                  sclDrvLow <= 1'b1;
                  sdaDrvLow <= 1'b1;
                end
                2'h1: sclDrvLow <= 1'b0;
                2'h2: sdaDrvLow <= 1'b0;
                2'h3:
                begin
                  owner_reg     <= 1'b0;
                  highSpeedMode <= 1'b0;
                  irq           <= 1'b1;
                  state_reg     <= i2cm_pkg::ST_IDLE_S;
                end
              endcase
            end
          default: state_reg <= i2cm_pkg::ST_IDLE_S;
        endcase
    end
  end

  // Open-drain pins, enable low means driving low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = !sclDrvLow;
  assign sdaOe  = !sdaDrvLow;

  property p_clear_idle;
    @(posedge sys_clk) disable iff (rst) clear_reg |=> state_reg == i2cm_pkg::ST_IDLE_S;
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("clear did not idle");

  property p_clear_self;
    @(posedge sys_clk) disable iff (rst) clear_reg && !cmdWrite |=> !clear_reg;
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear stuck");

  property p_wait_bus;
    @(posedge sys_clk) disable iff (rst)
      state_reg == i2cm_pkg::ST_WAITBUS && line_occupied && !clear_reg |=> state_reg != i2cm_pkg::ST_START;
  endproperty
  a_wait_bus: assert property (p_wait_bus) else $error("start on busy bus");

  property p_arb_release;
    @(posedge sys_clk) disable iff (rst)
      $rose(arbitration_lost_flag) |-> sclOe && state_reg == i2cm_pkg::ST_IDLE_S;
  endproperty
  a_arb_release: assert property (p_arb_release) else $error("lines held after arb loss");

  property p_err_irq;
    @(posedge sys_clk) disable iff (rst) $rose(arbitration_lost_flag) |-> irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("no irq on arb loss");

  property p_quarter_min;
    @(posedge sys_clk) disable iff (rst) tickEn |=> (!tickEn) [*2];
  endproperty
  a_quarter_min: assert property (p_quarter_min) else $error("scl too fast");

  property p_occ_start;
    @(posedge sys_clk) disable iff (rst)
      sclF && sclPrev && sdaPrev && !sdaF |=> line_occupied;
  endproperty
  a_occ_start: assert property (p_occ_start) else $error("start not seen");

  property p_occ_stop;
    @(posedge sys_clk) disable iff (rst)
      sclF && sclPrev && !sdaPrev && sdaF |=> !line_occupied;
  endproperty
  a_occ_stop: assert property (p_occ_stop) else $error("stop not seen");
endmodule // i2cm_master

// *** design/i2cm_pkg.sv ***
package i2cm_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TARGET   = 8'hF4;
  localparam logic [7:0] ADDR_CMDSTAT  = 8'hF5;
  localparam logic [7:0] ADDR_DATA     = 8'hF6;
  localparam logic [7:0] ADDR_PERIOD   = 8'hF7;
  // Reset values
  localparam logic [7:0] RST_TARGET    = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_PERIOD    = 8'h00;
  // Command bit positions
  localparam int CMD_RUN    = 0;
  localparam int CMD_START  = 1;
  localparam int CMD_STOP   = 2;
  localparam int CMD_ACK    = 3;
  localparam int CMD_HS     = 4;
  localparam int CMD_FILT   = 6;
  localparam int CMD_CLEAR  = 7;
  // Status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_ERROR   = 1;
  localparam int ST_ADDRNAK = 2;
  localparam int ST_DATANAK = 3;
  localparam int ST_ARBITRATION_LOST_FLAG = 4;
  localparam int ST_IDLE    = 5;
  localparam int ST_OCC     = 6;
  // Timing
  localparam int  SYS_CLK_MHZ   = 25;
  localparam int  FILTER_NS     = 50;
  localparam int  FILTER_CYCLES = (FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int  QUARTER_MULT  = 2;
  localparam int  MIN_QUARTER   = 3;
  localparam logic [7:0] MASTER_CODE = 8'h08;

  typedef enum logic [3:0] {
    ST_IDLE_S  = 4'b0000,
    ST_WAITBUS = 4'b0001,
    ST_START   = 4'b0011,
    ST_BITS    = 4'b0010,
    ST_ACKBIT  = 4'b0110,
    ST_HOLD    = 4'b0111,
    ST_STOP    = 4'b0101,
    ST_RSTART  = 4'b0100,
    ST_PREP    = 4'b1100
  } i2cm_state_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic ack;
    logic hs;
  } i2cm_cmd_type;
endpackage

// *** test/i2cm_slave_model.sv ***
`timescale 1ns/1ps
module i2cm_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nackData,
  input  wire logic [7:0] readByte,
  output logic            sdaPull,
  output logic [7:0]      gotByte,
  output logic            masterAck
);
  logic [7:0] b;
  logic       restart;

  task automatic getByte();
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge scl);
      b[i] = sda;
    end
  endtask

  task automatic ackBit(input logic yes);
    @(negedge scl);
    sdaPull = yes;
    @(negedge scl);
    sdaPull = 1'b0;
  endtask

  initial
  begin
    sdaPull = 1'b0;
    gotByte = 8'h00;
    masterAck = 1'b0;
    b = 8'h00;
    restart = 1'b0;
    forever
    begin
      if (!restart)
        @(negedge sda iff scl === 1'b1);
      restart = 1'b0;
      fork
        begin
          getByte();
          if (b[7:1] == DEV_ADDR)
          begin
            ackBit(1'b1);
            if (b[0])
            begin
              do
              begin
                for (int i = 7; i >= 0; i--)
                begin
                  sdaPull = ~readByte[i];
                  @(negedge scl);
                end
                sdaPull = 1'b0;
                @(posedge scl);
                masterAck = ~sda;
                @(negedge scl);
              end while (masterAck);
            end
            else
            begin
              forever
              begin
                getByte();
                gotByte = b;
                ackBit(~nackData);
              end
            end
          end
        end
        @(posedge sda iff scl === 1'b1);
        begin
          @(negedge sda iff scl === 1'b1);
          restart = 1'b1;
        end
      join_any
      disable fork;
      sdaPull = 1'b0;
    end
  end
endmodule // i2cm_slave_model

// *** test/i2cm_master_test.sv ***
`timescale 1ns/1ps
module i2cm_master_test;
  localparam logic [7:0] A_T = i2cm_pkg::ADDR_TARGET;
  localparam logic [7:0] A_C = i2cm_pkg::ADDR_CMDSTAT;
  localparam logic [7:0] A_D = i2cm_pkg::ADDR_DATA;
  localparam logic [7:0] A_P = i2cm_pkg::ADDR_PERIOD;
  logic       sys_clk;
  logic       rst;
  logic       regWr;
  logic       regRd;
  logic       tbSdaLow;
  logic       slvNack;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic [7:0] rv;
  logic [7:0] slvGot;
  logic       sclOut;
  logic       sclOe;
  logic       sdaOut;
  logic       sdaOe;
  logic       highSpeedMode;
  logic       irq;
  logic       slvPull;
  logic       slvAck;
  wire        sclW = sclOe | sclOut;
  wire        sdaW = (sdaOe | sdaOut) & ~slvPull & ~tbSdaLow;
  wire        sdaSlv;
  int         error_cnt;
  int         samples_checked;
  int         irqCnt;
  int         cyc;

  i2cm_master uut (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdata      (regRdata),
    .sclIn         (sclW),
    .sclOut        (sclOut),
    .sclOe         (sclOe),
    .sdaIn         (sdaW),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .highSpeedMode (highSpeedMode),
    .irq           (irq)
  );

  // Line delay so data never moves at the same instant as SCL falls
  assign #1 sdaSlv = sdaW;

  i2cm_slave_model slv (
    .scl       (sclW),
    .sda       (sdaSlv),
    .nackData  (slvNack),
    .readByte  (8'h3C),
    .sdaPull   (slvPull),
    .gotByte   (slvGot),
    .masterAck (slvAck)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk)
  begin
    if (irq === 1'b1)
      irqCnt++;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("[ERR] %0t run too long", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    rv = regRdata;
    @(posedge sys_clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rv, exp);
  endtask

  task automatic waitIrq();
    int n0;
    n0 = irqCnt;
    for (int i = 0; i < 20000 && irqCnt == n0; i++)
      @(posedge sys_clk);
    chk(8'(irqCnt - n0), 8'h01);
  endtask

  task automatic done(input logic [7:0] exp, input logic [7:0] msk);
    waitIrq();
    for (int i = 0; i < 40; i++)
    begin
      rd(A_C);
      if (rv[5] === 1'b1)
        break;
    end
    chk(rv & msk, exp);
  endtask

  task automatic perChk(input int exp);
    realtime t0;
    repeat (3) @(posedge sclW);
    t0 = $realtime;
    @(posedge sclW);
    chk(8'(int'(($realtime - t0) / 40.0)), 8'(exp));
    @(posedge sys_clk);
  endtask

  initial
  begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    tbSdaLow = 1'b0;
    slvNack = 1'b0;
    rv = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk(A_T, 8'h00);
    rdChk(A_C, 8'h20);
    rdChk(A_D, 8'h00);
    rdChk(A_P, 8'h00);
    rdChk(8'hF3, 8'h00);
    wr(A_T, 8'hA1);
    rdChk(A_T, 8'hA1);
    wr(A_P, 8'h03);
    rdChk(A_P, 8'h03);
    $display("registers done");
    wr(A_T, 8'hA0);
    wr(A_D, 8'hC5);
    wr(A_C, 8'h03);
    perChk(32);
    rd(A_C);
    chk(rv & 8'h21, 8'h01);
    done(8'h40, 8'hFF);
    rdChk(A_C, 8'h40);
    chk(slvGot, 8'hC5);
    wr(A_D, 8'h96);
    wr(A_C, 8'h05);
    done(8'h20, 8'hFF);
    chk(slvGot, 8'h96);
    $display("burst write done");
    wr(A_P, 8'h00);
    wr(A_T, 8'hA1);
    wr(A_C, 8'h0B);
    perChk(12);
    waitIrq();
    rdChk(A_D, 8'h3C);
    chk({7'h00, slvAck}, 8'h01);
    wr(A_C, 8'h05);
    done(8'h20, 8'hFF);
    rdChk(A_D, 8'h3C);
    chk({7'h00, slvAck}, 8'h00);
    $display("burst read done");
    wr(A_P, 8'h03);
    wr(A_T, 8'hB0);
    wr(A_C, 8'h07);
    done(8'h26, 8'hFF);
    slvNack <= 1'b1;
    wr(A_T, 8'hA0);
    wr(A_C, 8'h07);
    done(8'h2A, 8'hFF);
    slvNack <= 1'b0;
    $display("nack done");
    wr(A_D, 8'h5A);
    wr(A_C, 8'h03);
    done(8'h40, 8'hFF);
    chk(slvGot, 8'h5A);
    wr(A_D, 8'hE7);
    wr(A_C, 8'h07);
    done(8'h20, 8'hFF);
    chk(slvGot, 8'hE7);
    $display("repeated start done");
    wr(A_C, 8'h11);
    waitIrq();
    chk({7'h00, highSpeedMode}, 8'h01);
    wr(A_C, 8'h04);
    done(8'h20, 8'h21);
    chk({7'h00, highSpeedMode}, 8'h00);
    $display("high speed done");
    tbSdaLow <= 1'b1;
    @(posedge sys_clk);
    tbSdaLow <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdChk(A_C, 8'h60);
    wr(A_C, 8'h40);
    tbSdaLow <= 1'b1;
    @(posedge sys_clk);
    tbSdaLow <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdChk(A_C, 8'h20);
    wr(A_C, 8'h00);
    $display("filter done");
    tbSdaLow <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdChk(A_C, 8'h60);
    wr(A_D, 8'h3F);
    wr(A_C, 8'h07);
    repeat (100) @(posedge sys_clk);
    chk({6'h00, sclOe, sdaOe}, 8'h03);
    tbSdaLow <= 1'b0;
    done(8'h20, 8'hFF);
    chk(slvGot, 8'h3F);
    $display("occupied bus done");
    wr(A_T, 8'hFE);
    wr(A_C, 8'h07);
    for (int i = 0; i < 2000 && sdaOe !== 1'b0; i++)
      @(posedge sys_clk);
    tbSdaLow <= 1'b1;
    waitIrq();
    chk({6'h00, sclOe, sdaOe}, 8'h03);
    tbSdaLow <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdChk(A_C, 8'h32);
    $display("arbitration done");
    wr(A_T, 8'hA0);
    wr(A_C, 8'h07);
    repeat (3) @(posedge sclW);
    @(posedge sys_clk);
    wr(A_C, 8'h80);
    repeat (4) @(posedge sys_clk);
    rd(A_C);
    chk(rv & 8'hA1, 8'h20);
    chk({6'h00, sclOe, sdaOe}, 8'h03);
    $display("clear done");
    close_out();
  end
endmodule // i2cm_master_test
